// ---- tb/swcf_top_properties.sv ----
// concurrent checks on the register bus and output code of the slew block
`timescale 1ns/1ps
module swcf_top_props
  import swcf_pkg::*;
#(
  parameter int CODE_W = 12
) (
  input wire logic              ref_clk,
  input wire logic              rstn,
  input wire logic [7:0]        avs_address,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_writedata,
  input wire logic [3:0]        avs_byteenable,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [CODE_W-1:0] outCode,
  input wire logic              slewBusy
);
  logic [12:0] cfgSh;
  logic [12:0] next_cfgSh;
  logic [12:0] laneMask;
  logic [5:0]  stepV;
  logic        runLin;
  logic        runLog;
  logic        waveOn;
  // shadow of the config word, updated at the commit edge
  assign laneMask   = {{5{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign next_cfgSh = (avs_write && !avs_waitrequest && avs_address == SWCF_REG_CFG) ?
                      (cfgSh & ~laneMask) | (avs_writedata[12:0] & laneMask) : cfgSh;
  assign stepV      = SWCF_STEP_LSB_TAB[cfgSh[6:4]];
  assign runLin     = cfgSh[10:8] == SWCF_FN_OFF && !cfgSh[7] && cfgSh[3:0] != 4'h0;
  assign runLog     = cfgSh[10:8] == SWCF_FN_OFF && cfgSh[7];
  assign waveOn     = cfgSh[10:8] inside {3'h0, 3'h1, 3'h2, 3'h4};
  always_ff @(posedge ref_clk) begin
    cfgSh <= !rstn ? SWCF_CFG_RST : next_cfgSh;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence reqSeen;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence oneWait;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  chk_one_wait: assert property (reqSeen |=> oneWait)
    else $error("wait state is not exactly one cycle");
  chk_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without a request");
  chk_rdata_hold: assert property (!$past(avs_read && avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved without a read");
  chk_reset_clear: assert property (disable iff (1'b0) !rstn |=>
    avs_waitrequest && avs_readdata == 32'h0 && outCode == '0 && !slewBusy)
    else $error("outputs not cleared by reset");
  chk_idle_hold: assert property ((cfgSh[3:0] != 4'h0 || cfgSh[7]) && !slewBusy
    && $past(!slewBusy) |-> $stable(outCode))
    else $error("output code moved while idle");
  chk_lin_step: assert property (runLin && $past(runLin) && $past(slewBusy)
    && outCode != $past(outCode) |->
    (outCode - $past(outCode) <= stepV) || ($past(outCode) - outCode <= stepV))
    else $error("linear step larger than step size");
  chk_log_step: assert property (runLog && $past(runLog) && outCode != $past(outCode) |->
    (outCode - $past(outCode) <= ($past(outCode) >> 5) + 2) ||
    ($past(outCode) - outCode <= ($past(outCode) >> 5) + 2))
    else $error("logarithmic step too large");
  chk_wave_busy: assert property (waveOn && cfgSh == $past(cfgSh, 3) && $past(rstn, 3)
    |-> slewBusy)
    else $error("waveform selected but block idle");
endmodule

bind swcf_top swcf_top_props #(.CODE_W(CODE_W)) u_props (
  .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .outCode(outCode),
  .slewBusy(slewBusy));

// ---- tb/swcf_top_test.sv ----
// self-checking bench for the waveform and slew configuration block
`timescale 1ns/1ps
module swcf_top_test;
  import swcf_pkg::*;
  // short intervals keep the run brief; log code i uses entry 2i+1
  localparam int unsigned RC [16] = '{1, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18};
  localparam int STEPS [8] = '{1, 2, 3, 4, 6, 8, 16, 32};
  localparam int DEG [4]   = '{0, 120, 240, 90};
  logic        ref_clk;
  logic        rstn;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [11:0] outCode;
  logic        slewBusy;
  logic [31:0] dummy;
  int          miscompares;
  int          testsRun;
  int          cycles;

  swcf_top #(.CODE_W(12), .RATE_CYC(RC)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .outCode(outCode),
    .slewBusy(slewBusy));

  always #4 ref_clk = ~ref_clk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, m, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hF, dummy);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(q, exp, m);
  endtask

  task automatic wait_chg(output int c);
    logic [11:0] old;
    old = outCode;
    c = 0;
    do begin
      @(posedge ref_clk);
      c++;
    end while (outCode === old);
  endtask

  task automatic wait_val(input logic [11:0] v, output int c);
    c = 0;
    while (outCode !== v) begin
      @(posedge ref_clk);
      c++;
    end
  endtask

  task automatic test_regs();
    rd(SWCF_REG_CFG, 32'h0, "cfg reset");
    rd(SWCF_REG_LOW, 32'h0, "low reset");
    rd(SWCF_REG_HIGH, 32'h0, "high reset");
    rd(SWCF_REG_CTRL, 32'h0, "ctrl reset");
    wr(SWCF_REG_CFG, 32'hFFFF_FFFF);
    rd(SWCF_REG_CFG, 32'h1FFF, "cfg width");
    bus(1'b1, SWCF_REG_CFG, 32'h0, 4'h1, dummy);
    rd(SWCF_REG_CFG, 32'h1F00, "cfg lane");
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0, "unmapped");
    $display("test_regs done");
  endtask

  task automatic test_linear();
    int c;
    logic [11:0] v;
    wr(SWCF_REG_HIGH, 32'h3FF);
    for (int k = 0; k < 8; k++) begin
      wr(SWCF_REG_CFG, 32'h0700 | (k << 4) | (k + 1));
      wr(SWCF_REG_CTRL, 32'h1);
      wait_chg(c);
      v = outCode;
      wait_chg(c);
      chk(c, RC[k + 1], "step time");
      chk(outCode - v, STEPS[k], "step size");
      wr(SWCF_REG_CFG, 32'h0700);
      wait_val(12'h3FF, c);
      chk(c < 4, 1'b1, "jump up");
      wr(SWCF_REG_CTRL, 32'h0);
      wait_val(12'h0, c);
      chk(c < 4, 1'b1, "jump down");
    end
    $display("test_linear done");
  endtask

  task automatic test_log();
    int c;
    logic [11:0] v;
    logic [11:0] e;
    wr(SWCF_REG_HIGH, 32'h100);
    wr(SWCF_REG_CFG, 32'h0795);
    wr(SWCF_REG_CTRL, 32'h1);
    wait_chg(c);
    chk(outCode, 12'h1, "log start");
    while (outCode != 12'h100) begin
      v = outCode;
      e = v + ((v >> 5) > 0 ? v >> 5 : 12'h1);
      wait_chg(c);
      chk(outCode, e > 12'h100 ? 12'h100 : e, "log up");
      chk(c, RC[3], "rise time");
    end
    wr(SWCF_REG_CTRL, 32'h0);
    while (outCode != 12'h0) begin
      v = outCode;
      e = v - ((v >> 5) > 0 ? v >> 5 : 12'h1);
      wait_chg(c);
      chk(outCode, e, "log down");
      if (v != 12'h100) chk(c, RC[5], "fall time");
    end
    $display("test_log done");
  endtask

  task automatic test_wave();
    int c;
    int d;
    logic [11:0] v;
    logic [2:0] fn [4];
    fn = '{3'h0, 3'h1, 3'h2, 3'h4};
    wr(SWCF_REG_HIGH, 32'hFF);
    for (int p = 0; p < 4; p++) begin
      wr(SWCF_REG_CFG, 32'h0700);
      wait_val(12'h0, c);
      wr(SWCF_REG_CFG, (p << 11) | 32'h0101);
      wait_chg(c);
      d = int'(outCode) - DEG[p] * 256 / 360;
      chk(d >= -1 && d <= 3, 1'b1, "phase offset");
    end
    for (int f = 0; f < 4; f++) begin
      wr(SWCF_REG_CFG, 32'h0700);
      wait_val(12'h0, c);
      // a 32-LSB phase step moves every shape, sine included, on each tick
      wr(SWCF_REG_CFG, {fn[f], 8'h71});
      wait_chg(c);
      v = outCode;
      wait_chg(c);
      chk(c, RC[1], "wave tick");
      chk((outCode > v) == (f != 2), 1'b1, "wave slope");
      chk(slewBusy, 1'b1, "wave busy");
    end
    wr(SWCF_REG_CFG, 32'h0700);
    wait_val(12'h0, c);
    repeat (3) @(posedge ref_clk);
    chk(slewBusy, 1'b0, "generation off");
    $display("test_wave done");
  endtask

  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    miscompares = 0;
    testsRun = 0;
    cycles = 0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    test_regs();
    test_linear();
    test_log();
    test_wave();
    finish_test();
  end
endmodule

// ---- verilog/swcf_pkg.sv ----
// constants and types shared by the waveform and slew configuration block
package swcf_pkg;
  // register byte offsets
  localparam logic [7:0] SWCF_REG_CFG  = 8'h00;
  localparam logic [7:0] SWCF_REG_LOW  = 8'h04;
  localparam logic [7:0] SWCF_REG_HIGH = 8'h08;
  localparam logic [7:0] SWCF_REG_CTRL = 8'h0C;
  localparam logic [7:0] SWCF_REG_STAT = 8'h10;

  // waveform_config_block field positions and reset
  localparam int          SWCF_CFG_W     = 13;
  localparam int          SWCF_PHASE_LSB = 11;
  localparam int          SWCF_FUNC_LSB  = 8;
  localparam int          SWCF_LOG_BIT   = 7;
  localparam int          SWCF_STEP_LSB  = 4;
  localparam int          SWCF_RATE_LSB  = 0;
  localparam int          SWCF_RISE_LSB  = 4;
  localparam int          SWCF_FALL_LSB  = 1;
  localparam logic [12:0] SWCF_CFG_RST   = 13'h0000;
  localparam int          SWCF_STAT_BUSY = 16;

  // waveform selector codes
  localparam logic [2:0] SWCF_FN_TRI  = 3'h0;
  localparam logic [2:0] SWCF_FN_SAW  = 3'h1;
  localparam logic [2:0] SWCF_FN_INV  = 3'h2;
  localparam logic [2:0] SWCF_FN_SINE = 3'h4;
  localparam logic [2:0] SWCF_FN_OFF  = 3'h7;

  // phase offsets in 1/256 of a period: 0, 120, 240, 90 degrees
  localparam logic [7:0] SWCF_PHASE_OFS [4] = '{8'h00, 8'h55, 8'hAB, 8'h40};
  // linear step sizes in LSB
  localparam logic [5:0] SWCF_STEP_LSB_TAB [8] =
    '{6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h10, 6'h20};
  // quarter sine, amplitude 127, 16 points
  localparam logic [7:0] SWCF_SINE_Q [16] = '{8'h00, 8'h0C, 8'h19, 8'h25, 8'h31, 8'h3C,
    8'h47, 8'h51, 8'h5A, 8'h62, 8'h6A, 8'h70, 8'h75, 8'h7A, 8'h7D, 8'h7F};

  // step intervals in ns, index = linear interval code
  localparam int SWCF_CLK_NS = 8;
  localparam int SWCF_RATE_NS [16] = '{0, 4000, 8000, 12000, 18000, 27040, 40480, 60720,
    91120, 136720, 239200, 418640, 732560, 1282000, 2564000, 5127920};
  localparam int SWCF_CNT_W = 20;

  function automatic int unsigned swcf_rate_cyc(input int idx);
    int unsigned c;
    c = SWCF_RATE_NS[idx] / SWCF_CLK_NS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned SWCF_RATE_CYC [16] = '{swcf_rate_cyc(0), swcf_rate_cyc(1),
    swcf_rate_cyc(2), swcf_rate_cyc(3), swcf_rate_cyc(4), swcf_rate_cyc(5),
    swcf_rate_cyc(6), swcf_rate_cyc(7), swcf_rate_cyc(8), swcf_rate_cyc(9),
    swcf_rate_cyc(10), swcf_rate_cyc(11), swcf_rate_cyc(12), swcf_rate_cyc(13),
    swcf_rate_cyc(14), swcf_rate_cyc(15)};

  typedef enum logic [2:0] {
    SWCF_ST_IDLE = 3'b001,
    SWCF_ST_SLEW = 3'b010,
    SWCF_ST_WAVE = 3'b100
  } swcf_state_t;
endpackage

// ---- verilog/swcf_step_timer.sv ----
// interval timer giving one tick per step period
`timescale 1ns/1ps
module swcf_step_timer #(
  parameter int CNT_W = 20
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             restart,
  input  wire logic [CNT_W-1:0] period,
  output logic                  tick
);
  logic [CNT_W-1:0] count;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count <= '0;
      tick  <= 1'b0;
    end else if (restart || count == '0) begin
      // period holds cycles minus one, so a zero period ticks every cycle
      count <= period;
      tick  <= !restart;
    end else begin
      count <= count - 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- verilog/swcf_top.sv ----
// per-channel waveform generator and slew engine with Avalon-MM registers
// Behaviour
// R01: phase select offsets waveform by 0, 120, 240 or 90 degrees.
// R02: waveform codes 000, 001, 010 give triangle, sawtooth, inverse sawtooth.
// R03: code 100 gives sine, 111 disables generation; other codes invalid.
// R04: mode bit picks linear when clear, logarithmic when set.
// R05: linear step code gives 1, 2, 3, 4, 6, 8, 16 or 32 LSB.
// R06: linear interval code 0000 jumps straight to the bound.
// R07: linear interval code sets time per step, 4 us up to 5127.92 us.
// R08: logarithmic mode moves between bounds with 3.125 percent step change.
// R09: upward logarithmic step multiplies current value by 1.03125.
// R10: downward logarithmic step multiplies current value by 0.96875.
// R11: logarithmic slew from a zero lower bound starts at code 1.
// R12: logarithmic rise interval from bits 6-4, table 4 to 5127.92 us.
// R13: logarithmic fall interval from bits 3-1, same table, bit 0 ignored.
// R14: 239.2 us is code 1010; code 1110 given a chosen interval.
// R15: all configuration resets to zero.
`timescale 1ns/1ps
module swcf_top
  import swcf_pkg::*;
#(
  parameter int          CODE_W        = 12,
  parameter int unsigned RATE_CYC [16] = swcf_pkg::SWCF_RATE_CYC
) (
  input  wire logic                ref_clk,
  input  wire logic                rstn,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic      [31:0]         avs_readdata,
  output logic                     avs_waitrequest,
  output logic      [CODE_W-1:0]   outCode,
  output logic                     slewBusy
);
  import swcf_pkg::*;

  if (CODE_W < 8 || CODE_W > 16) begin : g_bad_width
    $error("swcf_top: CODE_W must lie between 8 and 16");
  end
  for (genvar g = 0; g < 16; g++) begin : g_rate_chk
    if (RATE_CYC[g] == 0 || RATE_CYC[g] > (1 << SWCF_CNT_W)) begin : g_bad_rate
      $error("swcf_top: RATE_CYC entry out of timer range");
    end
  end

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    return (old & ~lane_mask(be)) | (wd & lane_mask(be));
  endfunction

  // ---------------- registers
  logic        [SWCF_CFG_W-1:0] cfg;
  logic        [CODE_W-1:0]     lowCode;
  logic        [CODE_W-1:0]     highCode;
  logic                         ctrlTarget;
  logic        [7:0]            phase;
  swcf_state_t                  state;
  swcf_state_t                  next_state;

  // ---------------- bus decode
  // one wait state: waitrequest drops the cycle after a request is seen
  wire         busReq    = (avs_read || avs_write) && avs_waitrequest;
  wire         busCommit = avs_write && !avs_waitrequest;
  wire         selCfg    = avs_address == SWCF_REG_CFG;
  wire         selLow    = avs_address == SWCF_REG_LOW;
  wire         selHigh   = avs_address == SWCF_REG_HIGH;
  wire         selCtrl   = avs_address == SWCF_REG_CTRL;
  wire         selStat   = avs_address == SWCF_REG_STAT;
  wire  [31:0] wrCfg     = merge({{(32-SWCF_CFG_W){1'b0}}, cfg}, avs_writedata, avs_byteenable);
  wire  [31:0] wrLow     = merge({{(32-CODE_W){1'b0}}, lowCode}, avs_writedata, avs_byteenable);
  wire  [31:0] wrHigh    = merge({{(32-CODE_W){1'b0}}, highCode}, avs_writedata,
                                 avs_byteenable);
  wire         cfgWrite  = busCommit && selCfg;
  logic [31:0] rdMux;

  always_comb begin
    if (selCfg) begin
      rdMux = {{(32-SWCF_CFG_W){1'b0}}, cfg};
    end else if (selLow) begin
      rdMux = {{(32-CODE_W){1'b0}}, lowCode};
    end else if (selHigh) begin
      rdMux = {{(32-CODE_W){1'b0}}, highCode};
    end else if (selCtrl) begin
      rdMux = {31'h0, ctrlTarget};
    end else if (selStat) begin
      rdMux = {{(31-SWCF_STAT_BUSY){1'b0}}, slewBusy,
               {(SWCF_STAT_BUSY-CODE_W){1'b0}}, outCode};
    end else begin
      rdMux = 32'h0000_0000;
    end
  end

  // ---------------- configuration fields
  wire  [1:0]  phaseSel = cfg[SWCF_PHASE_LSB +: 2];
  wire  [2:0]  func     = cfg[SWCF_FUNC_LSB +: 3];
  wire         isLog    = cfg[SWCF_LOG_BIT]; // R04
  wire  [2:0]  stepCode = cfg[SWCF_STEP_LSB +: 3];
  wire  [3:0]  rateCode = cfg[SWCF_RATE_LSB +: 4];
  wire  [2:0]  riseCode = cfg[SWCF_RISE_LSB +: 3];
  wire  [2:0]  fallCode = cfg[SWCF_FALL_LSB +: 3];
  wire  [5:0]  stepLsb  = SWCF_STEP_LSB_TAB[stepCode]; // R05
  wire         waveOn   = func != SWCF_FN_OFF; // R03

  // ---------------- slew direction and interval
  wire  [CODE_W-1:0] target  = ctrlTarget ? highCode : lowCode;
  wire               goingUp = target > outCode;
  // logarithmic codes share the linear table: code i sits at linear code 2i+1
  wire  [3:0]        riseIdx = {riseCode, 1'b1}; // R12
  wire  [3:0]        fallIdx = {fallCode, 1'b1}; // R13
  wire  [3:0]        logIdx  = (waveOn || goingUp) ? riseIdx : fallIdx;
  wire  [3:0]        rateIdx = isLog ? logIdx : rateCode; // R07
  wire               noSlew  = !isLog && rateCode == 4'h0; // R06
  wire  [SWCF_CNT_W-1:0] period = SWCF_CNT_W'(RATE_CYC[rateIdx] - 1); // R07 R14
  wire               tick;

  swcf_step_timer #(
    .CNT_W   (SWCF_CNT_W)
  ) u_timer (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .restart (cfgWrite || state != next_state),
    .period  (period),
    .tick    (tick)
  );

  // ---------------- waveform path
  wire  [7:0]        wavePhase = phase + SWCF_PHASE_OFS[phaseSel]; // R01
  wire  [CODE_W-1:0] waveCode;

  swcf_wave_shape #(
    .CODE_W   (CODE_W)
  ) u_shape (
    .func     (func),
    .phase    (wavePhase),
    .lowCode  (lowCode),
    .highCode (highCode),
    .waveCode (waveCode)
  );

  // ---------------- linear slew
  wire  [CODE_W:0]   linUp   = {1'b0, outCode} + {{(CODE_W-5){1'b0}}, stepLsb};
  wire  [CODE_W:0]   linDn   = {1'b0, outCode} - {{(CODE_W-5){1'b0}}, stepLsb};
  wire               linUpOv = linUp > {1'b0, target};
  wire               linDnOv = linDn[CODE_W] || linDn[CODE_W-1:0] < target;
  wire  [CODE_W-1:0] linNext = goingUp ? (linUpOv ? target : linUp[CODE_W-1:0])
                                       : (linDnOv ? target : linDn[CODE_W-1:0]); // R05

  // ---------------- logarithmic slew
  // a zero start could never grow by a ratio, so it is lifted to 1
  wire  [CODE_W-1:0] logBase  = (outCode == '0) ? {{(CODE_W-1){1'b0}}, 1'b1} : outCode; // R11
  wire  [CODE_W-1:0] logFrac  = logBase >> 5;
  // below 32 the ratio rounds to nothing, so at least one code is moved
  wire  [CODE_W-1:0] logDelta = (logFrac == '0) ? {{(CODE_W-1){1'b0}}, 1'b1} : logFrac;
  // the first step off a zero bound lands on code 1 itself
  wire  [CODE_W:0]   logUp    = (outCode == '0) ? {{CODE_W{1'b0}}, 1'b1}
                                                : {1'b0, logBase} + {1'b0, logDelta}; // R09 R11
  wire  [CODE_W:0]   logDn    = {1'b0, outCode} - {1'b0, logDelta}; // R10
  wire               logUpOv  = logUp > {1'b0, target};
  wire               logDnOv  = logDn[CODE_W] || logDn[CODE_W-1:0] < target;
  wire  [CODE_W-1:0] logNext  = goingUp ? (logUpOv ? target : logUp[CODE_W-1:0])
                                        : (logDnOv ? target : logDn[CODE_W-1:0]); // R08
  wire  [CODE_W-1:0] slewNext = isLog ? logNext : linNext;

  // ---------------- state machine
  always_comb begin
    case (state)
      SWCF_ST_IDLE: next_state = waveOn ? SWCF_ST_WAVE
                               : (target != outCode) ? SWCF_ST_SLEW : SWCF_ST_IDLE;
      SWCF_ST_SLEW: next_state = waveOn ? SWCF_ST_WAVE
                               : (target == outCode) ? SWCF_ST_IDLE : SWCF_ST_SLEW;
      SWCF_ST_WAVE: next_state = waveOn ? SWCF_ST_WAVE : SWCF_ST_IDLE;
      default:      next_state = SWCF_ST_IDLE;
    endcase
  end

  logic [CODE_W-1:0] next_outCode;
  logic [7:0]        next_phase;

  always_comb begin
    next_outCode = outCode;
    next_phase   = phase;
    case (state)
      SWCF_ST_SLEW: begin
        if (noSlew) begin
          next_outCode = target; // R06
        end else if (tick) begin
          next_outCode = slewNext;
        end
      end
      SWCF_ST_WAVE: begin
        // the step code doubles as phase increment per tick
        if (tick) begin
          next_phase   = phase + {2'b00, stepLsb};
          next_outCode = waveCode;
        end
      end
      default: begin
        next_phase = 8'h00;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state    <= SWCF_ST_IDLE;
      outCode  <= '0;
      phase    <= 8'h00;
      slewBusy <= 1'b0;
    end else begin
      state    <= next_state;
      outCode  <= next_outCode;
      phase    <= next_phase;
      slewBusy <= next_state != SWCF_ST_IDLE;
    end
  end

  // ---------------- register writes and bus answer
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg        <= SWCF_CFG_RST; // R15
      lowCode    <= '0;
      highCode   <= '0;
      ctrlTarget <= 1'b0;
    end else if (busCommit) begin
      if (selCfg) begin
        cfg <= wrCfg[SWCF_CFG_W-1:0];
      end
      if (selLow) begin
        lowCode <= wrLow[CODE_W-1:0];
      end
      if (selHigh) begin
        highCode <= wrHigh[CODE_W-1:0];
      end
      if (selCtrl && avs_byteenable[0]) begin
        ctrlTarget <= avs_writedata[0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= !busReq;
      if (busReq && avs_read) begin
        avs_readdata <= rdMux;
      end
    end
  end
endmodule

// ---- verilog/swcf_wave_shape.sv ----
// maps a waveform phase onto a code between the two bounds
`timescale 1ns/1ps
module swcf_wave_shape
  import swcf_pkg::*;
#(
  parameter int CODE_W = 12
) (
  input  wire logic [2:0]        func,
  input  wire logic [7:0]        phase,
  input  wire logic [CODE_W-1:0] lowCode,
  input  wire logic [CODE_W-1:0] highCode,
  output logic      [CODE_W-1:0] waveCode
);
  wire        [3:0]         sineIdx = phase[6] ? ~phase[5:2] : phase[5:2];
  wire        [7:0]         sineMag = SWCF_SINE_Q[sineIdx];
  wire        [7:0]         sineVal = phase[7] ? 8'h80 - sineMag : 8'h80 + sineMag;
  wire        [7:0]         triVal  = phase[7] ? {~phase[6:0], 1'b0} : {phase[6:0], 1'b0};
  // reversed bounds give a flat output rather than wrapping
  wire        [CODE_W-1:0]  span    = (highCode > lowCode) ? highCode - lowCode : '0;
  logic       [7:0]         shape;
  wire        [CODE_W+7:0]  scaled  = span * shape;

  always_comb begin
    case (func)
      SWCF_FN_TRI:  shape = triVal; // R02
      SWCF_FN_SAW:  shape = phase; // R02
      SWCF_FN_INV:  shape = ~phase; // R02
      SWCF_FN_SINE: shape = sineVal; // R03
      default:      shape = 8'h00;
    endcase
  end

  assign waveCode = lowCode + scaled[CODE_W+7:8];
endmodule
